// [pkg/mux_seq_pkg.sv]
// Constants, register map and state carrier of the input mux sequencer.
package mux_seq_pkg;
   // ****************************************
   // Register map and field layout
   // ****************************************
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_NSEL0 = 8'h04;
   localparam logic [7:0] OFS_NSEL1 = 8'h08;
   localparam logic [7:0] OFS_ASEL0 = 8'h0c;
   localparam logic [7:0] OFS_ASEL1 = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam int CTRL_CNT = 0;
   localparam int CTRL_FLEN = 4;
   localparam int CTRL_CHOP = 6;
   localparam int CTRL_ALT = 8;
   localparam int CTRL_BME = 9;
   localparam int CTRL_DIFF = 10;
   localparam int CTRL_RUN = 14;
   localparam int CTRL_ACC = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ****************************************
   // Sequencer constants and reset values
   // ****************************************
   localparam int MAX_SLOTS = 10;
   localparam logic [3:0] LAST_SLOT_MAX = 4'h9;
   localparam logic [1:0] FLEN_MAX = 2'h2;
   localparam logic [3:0] SIG_VBAT = 4'hb;
   localparam logic [1:0] CHOP_AUTO = 2'h0;
   localparam logic [1:0] CHOP_POS = 2'h1;
   localparam logic [1:0] CHOP_REV = 2'h2;
   localparam logic [3:0] RST_SLOT_CNT = 4'h7;
   localparam logic [7:0] RST_ACC_LEN = 8'h02;
   localparam int RES_W = 28;
   localparam int FIFO_DEPTH = 16;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SLOT = 2'b01,
      ST_SYNC = 2'b11
   } seq_state_e;

   typedef struct packed {
      seq_state_e state;
      logic [3:0] slot;
      logic [1:0] cyc;
      logic alt;
      logic [7:0] frame_idx;
      logic chopper_polarity;
      logic chop_phase;
      logic alt_pend;
      logic req_q;
      logic ck_q;
      logic [3:0] slot_cnt;
      logic [1:0] flen;
      logic [1:0] chop_mode;
      logic alt_req;
      logic battery_measure_enable;
      logic [3:0] diff_en;
      logic run;
      logic [7:0] acc_len;
      logic [39:0] nsel;
      logic [39:0] asel;
      logic [3:0] mux_sel;
      logic mux_en;
      logic conv_start;
      logic frame_sync;
      logic eng_start;
      logic [3:0] pair_chop;
      logic [3:0] conv_sig;
      logic mem_valid;
      logic [3:0] mem_addr;
      logic [RES_W-1:0] mem_data;
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic aw_rdy;
      logic w_rdy;
      logic ar_rdy;
   } seq_state_s;
endpackage : mux_seq_pkg

// [core/adc_input_mux_sequencer.sv]
// Input mux sequencer with AXI4-Lite registers and result FIFO.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Result FIFO
// ****************************************
module mux_result_fifo #(
   parameter int W = 32,
   parameter int D = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic full;
      logic nempty;
   } fifo_s;
   fifo_s st;
   fifo_s next_st;

   // Full and not-empty are registered so the input ready and the output valid come from flops.
   always_comb begin
      logic push;
      logic pop;
      push = i_in_valid && !st.full;
      pop = i_out_ready && st.nempty;
      next_st = st;
      if (push) begin
         next_st.mem[st.wr] = i_in_data;
         next_st.wr = (st.wr == AW'(D - 1)) ? '0 : AW'(st.wr + 1'b1);
      end
      if (pop) begin
         next_st.rd = (st.rd == AW'(D - 1)) ? '0 : AW'(st.rd + 1'b1);
      end
      next_st.cnt = (AW + 1)'(st.cnt + push - pop);
      next_st.full = next_st.cnt == (AW + 1)'(D);
      next_st.nempty = next_st.cnt != '0;
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_in_ready = !st.full;
   assign o_out_valid = st.nempty;
   assign o_out_data = st.mem[st.rd];
endmodule : mux_result_fifo

// ****************************************
// Sequencer top
// ****************************************
module adc_input_mux_sequencer #(
   parameter int FIFO_W = 32,
   parameter int FIFO_D = mux_seq_pkg::FIFO_DEPTH
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_slow_clock_32k,
   input wire logic i_conv_done,
   input wire logic [mux_seq_pkg::RES_W-1:0] i_conv_data,
   output logic o_conv_ready,
   output logic o_conv_start,
   output logic [3:0] o_mux_select,
   output logic o_mux_enable,
   output logic o_battery_load,
   output logic [3:0] o_pair_chop,
   output logic o_chopper_polarity,
   output logic o_frame_sync_pulse,
   output logic o_engine_start,
   output logic o_mem_valid,
   output logic [3:0] o_mem_addr,
   output logic [mux_seq_pkg::RES_W-1:0] o_mem_data,
   input wire logic i_mem_ready,
   input wire logic [mux_seq_pkg::ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [mux_seq_pkg::ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);
   mux_seq_pkg::seq_state_s st;
   mux_seq_pkg::seq_state_s next_st;
   logic tick;
   logic f_out_valid;
   logic f_out_ready;
   logic [FIFO_W-1:0] f_out_data;

   // Register read view; top bit (bit 32) of the answer flags a mapped address.
   function automatic logic [32:0] rd_word(input mux_seq_pkg::seq_state_s s,
                                           input logic [7:0] a);
      logic [31:0] v;
      logic ok;
      v = '0;
      ok = 1'b1;
      case (a)
         mux_seq_pkg::OFS_CTRL: begin
            v[mux_seq_pkg::CTRL_CNT +: 4] = s.slot_cnt;
            v[mux_seq_pkg::CTRL_FLEN +: 2] = s.flen;
            v[mux_seq_pkg::CTRL_CHOP +: 2] = s.chop_mode;
            v[mux_seq_pkg::CTRL_ALT] = s.alt_req;
            v[mux_seq_pkg::CTRL_BME] = s.battery_measure_enable;
            v[mux_seq_pkg::CTRL_DIFF +: 4] = s.diff_en;
            v[mux_seq_pkg::CTRL_RUN] = s.run;
            v[mux_seq_pkg::CTRL_ACC +: 8] = s.acc_len;
         end
         mux_seq_pkg::OFS_NSEL0: v = s.nsel[31:0];
         mux_seq_pkg::OFS_NSEL1: v[7:0] = s.nsel[39:32];
         mux_seq_pkg::OFS_ASEL0: v = s.asel[31:0];
         mux_seq_pkg::OFS_ASEL1: v[7:0] = s.asel[39:32];
         mux_seq_pkg::OFS_STATUS: begin
            v = {8'h00, s.frame_idx, 6'h00, s.state, s.alt_pend,
                 s.frame_sync, s.chopper_polarity, s.alt, s.slot};
         end
         default: ok = 1'b0;
      endcase
      return {ok, v};
   endfunction : rd_word

   // The slow clock is sampled here; its rising edge paces the slot and frame sequence.
   assign tick = i_slow_clock_32k && !st.ck_q;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      logic [3:0] last;
      logic [1:0] flen_eff;
      logic [7:0] nidx;
      logic begin_slot;
      logic new_frame;
      logic consume;
      logic [32:0] rw;
      logic [31:0] m;
      logic [31:0] wv;
      logic [3:0] sel;
      last = '0;
      flen_eff = '0;
      nidx = '0;
      begin_slot = 1'b0;
      new_frame = 1'b0;
      consume = 1'b0;
      rw = '0;
      m = '0;
      wv = '0;
      sel = '0;
      next_st = st;
      next_st.ck_q = i_slow_clock_32k;
      next_st.conv_start = 1'b0;
      next_st.eng_start = 1'b0;
      // Zero slots still runs one; above ten is held at ten.
      if (st.slot_cnt == 4'h0) begin
         last = 4'h0;
      end else if (st.slot_cnt > 4'(mux_seq_pkg::MAX_SLOTS)) begin
         last = mux_seq_pkg::LAST_SLOT_MAX;
      end else begin
         last = 4'(st.slot_cnt - 1'b1);
      end
      flen_eff = (st.flen > mux_seq_pkg::FLEN_MAX) ?
                 mux_seq_pkg::FLEN_MAX : st.flen;
      nidx = (8'(st.frame_idx + 1'b1) >= st.acc_len) ?
             8'h00 : 8'(st.frame_idx + 1'b1);
      if (tick) begin
         case (st.state)
            mux_seq_pkg::ST_IDLE: begin
               if (st.run) begin
                  nidx = 8'h00;
                  new_frame = 1'b1;
               end
            end
            mux_seq_pkg::ST_SLOT: begin
               if (st.cyc >= flen_eff) begin
                  next_st.cyc = 2'h0;
                  if (st.slot >= last) begin
                     // Extra settle cycle: sync high, engine pass starts.
                     next_st.state = mux_seq_pkg::ST_SYNC;
                     next_st.frame_sync = 1'b1;
                     next_st.eng_start = 1'b1;
                     next_st.mux_en = 1'b0;
                     next_st.chop_phase = !st.chop_phase;
                     case (st.chop_mode)
                        mux_seq_pkg::CHOP_POS: next_st.chopper_polarity = 1'b0;
                        mux_seq_pkg::CHOP_REV: next_st.chopper_polarity = 1'b1;
                        // Hold before the forced frame so alternates differ.
                        mux_seq_pkg::CHOP_AUTO: begin
                           if (nidx != 8'(st.acc_len - 1'b1)) begin
                              next_st.chopper_polarity = !st.chopper_polarity;
                           end
                        end
                        default: next_st.chopper_polarity = !st.chopper_polarity;
                     endcase
                  end else begin
                     next_st.slot = 4'(st.slot + 1'b1);
                     begin_slot = 1'b1;
                  end
               end else begin
                  next_st.cyc = 2'(st.cyc + 1'b1);
               end
            end
            mux_seq_pkg::ST_SYNC: begin
               next_st.frame_sync = 1'b0;
               if (st.run) begin
                  new_frame = 1'b1;
               end else begin
                  next_st.state = mux_seq_pkg::ST_IDLE;
               end
            end
            default: next_st.state = mux_seq_pkg::ST_IDLE;
         endcase
      end
      // A frame begins at slot zero; pending or forced alternates apply.
      if (new_frame) begin
         next_st.state = mux_seq_pkg::ST_SLOT;
         next_st.slot = 4'h0;
         next_st.cyc = 2'h0;
         next_st.frame_idx = nidx;
         next_st.alt = st.alt_pend || (st.chop_mode == mux_seq_pkg::CHOP_AUTO
                       && nidx == 8'(st.acc_len - 1'b1));
         consume = st.alt_pend;
         begin_slot = 1'b1;
      end
      // One input per slot; a disabled battery path converts nothing.
      if (begin_slot) begin
         sel = next_st.alt ? st.asel[{next_st.slot, 2'b00} +: 4]
                           : st.nsel[{next_st.slot, 2'b00} +: 4];
         next_st.mux_sel = sel;
         next_st.mux_en = !(sel == mux_seq_pkg::SIG_VBAT && !st.battery_measure_enable);
         next_st.conv_start = next_st.mux_en;
         next_st.conv_sig = sel;
      end
      next_st.pair_chop = st.diff_en & {4{next_st.chop_phase}};
      // A request rise wins over the consuming frame start.
      next_st.req_q = st.alt_req;
      next_st.alt_pend = (st.alt_req && !st.req_q) ||
                         (st.alt_pend && !consume);
      // Results leave the FIFO toward the engine word of their signal.
      if (f_out_valid && f_out_ready) begin
         next_st.mem_valid = 1'b1;
         next_st.mem_addr = f_out_data[mux_seq_pkg::RES_W +: 4];
         next_st.mem_data = f_out_data[mux_seq_pkg::RES_W-1:0];
      end else if (i_mem_ready) begin
         next_st.mem_valid = 1'b0;
      end
      // AXI4-Lite write: address and data in either order.
      if (i_awvalid && st.aw_rdy) begin
         next_st.aw_have = 1'b1;
         next_st.aw_addr = i_awaddr;
      end
      if (i_wvalid && st.w_rdy) begin
         next_st.w_have = 1'b1;
         next_st.w_data = i_wdata;
         next_st.w_strb = i_wstrb;
      end
      if (st.bvalid && i_bready) begin
         next_st.bvalid = 1'b0;
      end
      if (st.aw_have && st.w_have && !st.bvalid) begin
         rw = rd_word(st, st.aw_addr);
         for (int b = 0; b < 4; b++) begin
            m[8*b +: 8] = {8{st.w_strb[b]}};
         end
         wv = (rw[31:0] & ~m) | (st.w_data & m);
         next_st.aw_have = 1'b0;
         next_st.w_have = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = rw[32] ? mux_seq_pkg::RESP_OKAY
                                : mux_seq_pkg::RESP_SLVERR;
         case (st.aw_addr)
            mux_seq_pkg::OFS_CTRL: begin
               next_st.slot_cnt = wv[mux_seq_pkg::CTRL_CNT +: 4];
               next_st.flen = wv[mux_seq_pkg::CTRL_FLEN +: 2];
               next_st.chop_mode = wv[mux_seq_pkg::CTRL_CHOP +: 2];
               next_st.alt_req = wv[mux_seq_pkg::CTRL_ALT];
               next_st.battery_measure_enable = wv[mux_seq_pkg::CTRL_BME];
               next_st.diff_en = wv[mux_seq_pkg::CTRL_DIFF +: 4];
               next_st.run = wv[mux_seq_pkg::CTRL_RUN];
               next_st.acc_len = wv[mux_seq_pkg::CTRL_ACC +: 8];
            end
            mux_seq_pkg::OFS_NSEL0: next_st.nsel[31:0] = wv;
            mux_seq_pkg::OFS_NSEL1: next_st.nsel[39:32] = wv[7:0];
            mux_seq_pkg::OFS_ASEL0: next_st.asel[31:0] = wv;
            mux_seq_pkg::OFS_ASEL1: next_st.asel[39:32] = wv[7:0];
            default: next_st.bvalid = 1'b1;
         endcase
      end
      // AXI4-Lite read: one outstanding, answered the next cycle.
      if (st.rvalid && i_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (i_arvalid && st.ar_rdy) begin
         rw = rd_word(st, i_araddr);
         next_st.rvalid = 1'b1;
         next_st.rdata = rw[31:0];
         next_st.rresp = rw[32] ? mux_seq_pkg::RESP_OKAY
                                : mux_seq_pkg::RESP_SLVERR;
      end
      next_st.aw_rdy = !next_st.aw_have && !next_st.bvalid;
      next_st.w_rdy = !next_st.w_have && !next_st.bvalid;
      next_st.ar_rdy = !next_st.rvalid;
   end

   // Only constants are loaded under reset.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= '0;
         st.slot_cnt <= mux_seq_pkg::RST_SLOT_CNT;
         st.acc_len <= mux_seq_pkg::RST_ACC_LEN;
         st.aw_rdy <= 1'b1;
         st.w_rdy <= 1'b1;
         st.ar_rdy <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Results are tagged with the signal of the slot that started them.
   mux_result_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_in_valid(i_conv_done),
      .o_in_ready(o_conv_ready),
      .i_in_data({st.conv_sig, i_conv_data}),
      .o_out_valid(f_out_valid),
      .i_out_ready(f_out_ready),
      .o_out_data(f_out_data)
   );
   assign f_out_ready = !st.mem_valid || i_mem_ready;

   assign o_conv_start = st.conv_start;
   assign o_mux_select = st.mux_sel;
   assign o_mux_enable = st.mux_en;
   assign o_battery_load = st.battery_measure_enable;
   assign o_pair_chop = st.pair_chop;
   assign o_chopper_polarity = st.chopper_polarity;
   assign o_frame_sync_pulse = st.frame_sync;
   assign o_engine_start = st.eng_start;
   assign o_mem_valid = st.mem_valid;
   assign o_mem_addr = st.mem_addr;
   assign o_mem_data = st.mem_data;
   assign o_awready = st.aw_rdy;
   assign o_wready = st.w_rdy;
   assign o_bresp = st.bresp;
   assign o_bvalid = st.bvalid;
   assign o_arready = st.ar_rdy;
   assign o_rdata = st.rdata;
   assign o_rresp = st.rresp;
   assign o_rvalid = st.rvalid;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);

   sequence sync_leave;
      st.state == mux_seq_pkg::ST_SYNC && tick;
   endsequence
   sequence frame_begin;
      st.state == mux_seq_pkg::ST_SLOT && st.slot == 4'h0 && st.cyc == 2'h0;
   endsequence

   a_slot_in_range: assert property (st.slot <= 4'h9)
      else $error("slot index beyond ten slots");
   a_frame_first: assert property (sync_leave ##0 st.run |=> frame_begin)
      else $error("frame did not start at slot zero");
   a_start_on_edge: assert property (o_conv_start |-> $past(tick))
      else $error("slot start off the slow clock edge");
   a_normal_pick: assert property (o_conv_start && !st.alt |->
      o_mux_select == st.nsel[{st.slot, 2'b00} +: 4])
      else $error("normal frame used wrong select");
   a_alt_pick: assert property (o_conv_start && st.alt |->
      o_mux_select == st.asel[{st.slot, 2'b00} +: 4])
      else $error("alternate frame used wrong select");
   a_battery_gate: assert property (o_mux_enable &&
      o_mux_select == mux_seq_pkg::SIG_VBAT |-> st.battery_measure_enable)
      else $error("battery converted while disabled");
   a_slot_length: assert property (st.cyc <= 2'h2 && st.cyc <= st.flen)
      else $error("slot longer than filter length");
   a_sync_one_cycle: assert property (sync_leave |=> !o_frame_sync_pulse)
      else $error("frame sync held beyond one slow cycle");
   a_engine_launch: assert property ($rose(o_frame_sync_pulse) |->
      o_engine_start ##1 !o_engine_start)
      else $error("engine start not on sync leading edge");
   a_alt_pending: assert property (st.alt_req && !st.req_q |=>
      st.alt_pend)
      else $error("alternate request edge lost");
endmodule : adc_input_mux_sequencer
`default_nettype wire

// [bench/adc_partner.sv]
// Behavioural converter and engine memory model facing the sequencer.
`timescale 1ns/1ps
`default_nettype none
module adc_partner (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_conv_start,
   input wire logic [3:0] i_mux_select,
   input wire logic i_stall,
   output logic o_conv_done,
   output logic [27:0] o_conv_data,
   output logic o_mem_ready
);
   logic [1:0] dly;
   logic [3:0] sel;
   // A result returns four cycles after each start and carries the signal
   // number, so the memory word it lands in can be judged by the bench.
   // After each result the data lines flip once, so stale values never match.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         dly <= 2'h0;
         sel <= 4'h0;
         o_conv_done <= 1'b0;
         o_conv_data <= 28'h0;
         o_mem_ready <= 1'b0;
      end else begin
         o_conv_done <= 1'b0;
         o_mem_ready <= !i_stall && !o_mem_ready;
         if (o_conv_done) begin
            o_conv_data <= ~o_conv_data;
         end
         if (i_conv_start) begin
            dly <= 2'h3;
            sel <= i_mux_select;
         end else if (dly != 2'h0) begin
            dly <= dly - 2'h1;
            if (dly == 2'h1) begin
               o_conv_done <= 1'b1;
               o_conv_data <= {24'h0, sel};
            end
         end
      end
   end
endmodule : adc_partner
`default_nettype wire

// [bench/tb_adc_input_mux_sequencer.sv]
// Self-checking testbench of the input mux sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_input_mux_sequencer;
   localparam logic [39:0] NSEL = 40'h21_7654_3531;
   localparam logic [39:0] ASEL = 40'h00_0000_06ba;
   localparam logic [31:0] C = 32'h0002_4043;
   logic i_clk_sys = 1'b0, i_rstn = 1'b0, i_slow_clock_32k = 1'b0;
   logic i_conv_done, i_mem_ready, stall = 1'b0, battery_measure_enable = 1'b0;
   logic [27:0] i_conv_data;
   logic o_conv_ready, o_conv_start, o_mux_enable, o_battery_load;
   logic o_chopper_polarity, o_frame_sync_pulse, o_engine_start, o_mem_valid;
   logic [3:0] o_mux_select, o_pair_chop, o_mem_addr;
   logic [27:0] o_mem_data;
   logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0;
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
   logic i_arvalid = 1'b0, i_rready = 1'b0;
   logic [31:0] i_wdata = 32'h0, o_rdata;
   logic [3:0] i_wstrb = 4'h0, watch;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0] o_bresp, o_rresp;
   logic [4:0] div = 5'h0;
   int n_mismatch = 0, n_tests = 0, cyc = 0;
   assign watch = {o_mem_valid, o_conv_ready, o_frame_sync_pulse, o_conv_start};
   adc_input_mux_sequencer dut (.i_clk_sys, .i_rstn, .i_slow_clock_32k,
      .i_conv_done, .i_conv_data, .o_conv_ready, .o_conv_start, .o_mux_select,
      .o_mux_enable, .o_battery_load, .o_pair_chop, .o_chopper_polarity,
      .o_frame_sync_pulse, .o_engine_start, .o_mem_valid, .o_mem_addr,
      .o_mem_data, .i_mem_ready, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
      .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
      .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
      .i_rready);
   adc_partner partner (.i_clk_sys, .i_rstn, .i_conv_start(o_conv_start),
      .i_mux_select(o_mux_select), .i_stall(stall), .o_conv_done(i_conv_done),
      .o_conv_data(i_conv_data), .o_mem_ready(i_mem_ready));
   // ****************************************
   // Clocks and monitors
   // ****************************************
   initial forever #2 i_clk_sys = ~i_clk_sys;
   // The slow tick is sped up to forty system cycles to keep the run short.
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      div <= (div == 5'h13) ? 5'h0 : div + 5'h1;
      if (div == 5'h13) i_slow_clock_32k <= ~i_slow_clock_32k;
      if (o_mux_enable && o_mux_select == 4'hb) chk("vbat", 32'(battery_measure_enable), 32'h1);
      if (o_mem_valid && i_mem_ready) chk("mem_addr", 32'(o_mem_addr), 32'(o_mem_data[3:0]));
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Waits a bounded time for one watched output to reach a level.
   task automatic wait_for(input int b, input logic v);
      int k;
      k = 0;
      while (watch[b] !== v && k < 3000) begin
         @(posedge i_clk_sys);
         k++;
      end
      chk("wait", 32'(watch[b]), 32'(v));
   endtask : wait_for
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge i_clk_sys);
      i_awaddr <= a;
      i_awvalid <= 1'b1;
      i_wdata <= d;
      i_wstrb <= 4'hf;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      do begin
         @(posedge i_clk_sys);
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      end while (!o_bvalid);
      i_bready <= 1'b0;
      chk("bresp", 32'(o_bresp), 32'(er));
      if (a == mux_seq_pkg::OFS_CTRL) battery_measure_enable = d[mux_seq_pkg::CTRL_BME];
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge i_clk_sys);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do begin
         @(posedge i_clk_sys);
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      end while (!o_rvalid);
      i_rready <= 1'b0;
      chk("rdata", o_rdata, ed);
      chk("rresp", 32'(o_rresp), 32'(er));
   endtask : rd
   // Follows one whole frame from its first slot up to the sync cycle.
   task automatic expect_frame(input logic alt, input int n, input int gap);
      logic [3:0] e;
      int t, k;
      t = 0;
      k = 0;
      wait_for(1, 1'b1);
      wait_for(1, 1'b0);
      for (int i = 0; i < n; i++) begin
         e = alt ? ASEL[4*i +: 4] : NSEL[4*i +: 4];
         if (e == 4'hb && !battery_measure_enable) continue;
         wait_for(0, 1'b1);
         chk("mux_select", 32'(o_mux_select), 32'(e));
         chk("mux_enable", 32'(o_mux_enable), 32'h1);
         if (t != 0 && gap != 0) chk("slot_gap", 32'(cyc - t), 32'(gap));
         t = cyc;
         @(posedge i_clk_sys);
      end
      while (!watch[1] && !watch[0] && k < 3000) begin
         @(posedge i_clk_sys);
         k++;
      end
      chk("frame_sync", 32'(o_frame_sync_pulse), 32'h1);
      chk("engine_start", 32'(o_engine_start), 32'h1);
   endtask : expect_frame
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs;
      rd(mux_seq_pkg::OFS_CTRL, 32'h0002_0007, mux_seq_pkg::RESP_OKAY);
      rd(8'h18, 32'h0, mux_seq_pkg::RESP_SLVERR);
      wr(8'h18, 32'hffff_ffff, mux_seq_pkg::RESP_SLVERR);
      wr(mux_seq_pkg::OFS_NSEL0, NSEL[31:0], mux_seq_pkg::RESP_OKAY);
      wr(mux_seq_pkg::OFS_NSEL1, 32'(NSEL[39:32]), mux_seq_pkg::RESP_OKAY);
      wr(mux_seq_pkg::OFS_ASEL0, ASEL[31:0], mux_seq_pkg::RESP_OKAY);
      rd(mux_seq_pkg::OFS_NSEL1, 32'h21, mux_seq_pkg::RESP_OKAY);
   endtask : t_regs
   // A short alternate request pulse gives exactly one alternate frame.
   task automatic t_frames;
      wr(mux_seq_pkg::OFS_CTRL, C, mux_seq_pkg::RESP_OKAY);
      expect_frame(1'b0, 3, 40);
      chk("chopper_polarity", 32'(o_chopper_polarity), 32'h0);
      wr(mux_seq_pkg::OFS_CTRL, C | 32'h100, mux_seq_pkg::RESP_OKAY);
      wr(mux_seq_pkg::OFS_CTRL, C, mux_seq_pkg::RESP_OKAY);
      expect_frame(1'b1, 3, 0);
      expect_frame(1'b0, 3, 40);
      wr(mux_seq_pkg::OFS_CTRL, C | 32'h300, mux_seq_pkg::RESP_OKAY);
      wr(mux_seq_pkg::OFS_CTRL, C | 32'h200, mux_seq_pkg::RESP_OKAY);
      chk("battery_load", 32'(o_battery_load), 32'h1);
      expect_frame(1'b1, 3, 40);
      expect_frame(1'b0, 3, 40);
   endtask : t_frames
   // A count above ten is capped, and the longest filter spans three ticks.
   task automatic t_long;
      wr(mux_seq_pkg::OFS_CTRL, 32'h0002_406c, mux_seq_pkg::RESP_OKAY);
      expect_frame(1'b0, 10, 120);
   endtask : t_long
   // The engine stalls until the buffer refuses, then drains it empty.
   task automatic t_buffer;
      wr(mux_seq_pkg::OFS_CTRL, C, mux_seq_pkg::RESP_OKAY);
      stall <= 1'b1;
      wait_for(2, 1'b0);
      wr(mux_seq_pkg::OFS_CTRL, 32'h0002_0043, mux_seq_pkg::RESP_OKAY);
      stall <= 1'b0;
      wait_for(2, 1'b1);
      wait_for(3, 1'b0);
   endtask : t_buffer
   // Mode zero forces every second frame alternate and holds the polarity
   // before it; differential pairs flip their chop connection each frame.
   task automatic t_chop;
      logic [3:0] p;
      repeat (200) @(posedge i_clk_sys);
      wr(mux_seq_pkg::OFS_CTRL, 32'h0002_7c03, mux_seq_pkg::RESP_OKAY);
      expect_frame(1'b1, 3, 0);
      chk("chopper_polarity", 32'(o_chopper_polarity), 32'h1);
      p = o_pair_chop;
      expect_frame(1'b0, 3, 40);
      chk("chopper_polarity", 32'(o_chopper_polarity), 32'h1);
      chk("pair_chop", 32'(o_pair_chop), 32'(p ^ 4'hf));
   endtask : t_chop
   task automatic close_out;
      $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   initial begin
      repeat (2) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      t_regs();
      t_frames();
      t_long();
      t_buffer();
      t_chop();
      close_out();
   end
   // The full run needs under nine thousand cycles.
   initial begin
      repeat (30000) @(posedge i_clk_sys);
      n_mismatch++;
      close_out();
   end
endmodule : tb_adc_input_mux_sequencer
`default_nettype wire
